// ==== include/exec_pkg.sv ====
// Notes on behaviour
// - Invert op complements file register, updates zero
// - Invert dest bit 0 to accumulator, 1 back
// - Decrement op subtracts one, updates zero flag
// - Decrement dest bit 0 to accumulator, 1 back
// - Watchdog service clears counter and prescaler
// - Watchdog service sets expiry, sleep flags only
`default_nettype none
package exec_pkg;

   // ------------------------------------------------------------
   // Instruction encodings (14-bit words)
   // ------------------------------------------------------------
   localparam logic [13:0] ACC_CLEAR_WORD = 14'h0103;
   localparam logic [13:0] KICK_DOG_WORD = 14'h0064;
   localparam logic [5:0] INVERT_OPC = 6'h09;
   localparam logic [5:0] MINUS_ONE_OPC = 6'h03;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int OPC_MSB = 13;
   localparam int OPC_LSB = 8;
   localparam int DEST_BIT = 7;
   localparam int FADDR_MSB = 6;

   // ------------------------------------------------------------
   // AHB-Lite register map and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] INSTR_OFFSET = 8'h00;
   localparam logic [7:0] ACC_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] DOG_OFFSET = 8'h0c;
   localparam logic [7:0] FILE_BASE = 8'h80;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [2:0] STATUS_RESET = 3'h6;
   localparam int ZERO_POS = 0;
   localparam int SLEEP_POS = 1;
   localparam int EXPIRY_POS = 2;

   // Executor states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01
   } exec_state_t;

endpackage : exec_pkg
`default_nettype wire

// ==== core/exec_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Combinational decode of the four operations and result for invert and decrement
// ---------------------------------------------------------------
module exec_alu
   import exec_pkg::*;
(
   // Operands
   input wire logic [13:0] word_in,
   input wire logic [7:0] freg_in,
   // Result and decode flags
   output logic [7:0] result_out,
   output logic is_acc_clear_out,
   output logic is_invert_out,
   output logic is_minus_out,
   output logic is_kick_out
);

   // Decode and compute in one place
   always_comb begin
      is_acc_clear_out = (word_in == ACC_CLEAR_WORD);
      is_kick_out = (word_in == KICK_DOG_WORD);
      is_invert_out = (word_in[OPC_MSB:OPC_LSB] == INVERT_OPC);
      is_minus_out = (word_in[OPC_MSB:OPC_LSB] == MINUS_ONE_OPC);
      result_out = 8'h00;
      if (is_invert_out) begin
         result_out = ~freg_in;
      end else if (is_minus_out) begin
         result_out = freg_in - 8'h01;
      end
   end

endmodule : exec_alu
`default_nettype wire

// ==== core/exec_top.sv ====
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Executor for clear, invert, decrement and watchdog service
// ---------------------------------------------------------------
module exec_top
   import exec_pkg::*;
#(
   parameter int DOG_WIDTH = 8,
   parameter int PRESCALE_WIDTH = 8
) (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   // AHB-Lite slave
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   // Watchdog count and executor busy seen by the core
   output logic [7:0] DOG_COUNT_OUT,
   output logic BUSY_OUT
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (DOG_WIDTH < 1 || DOG_WIDTH > 8) begin : g_bad_dog
      $error("DOG_WIDTH must be 1 to 8");
   end
   if (PRESCALE_WIDTH < 1 || PRESCALE_WIDTH > 8) begin : g_bad_pre
      $error("PRESCALE_WIDTH must be 1 to 8");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] file_q [0:127];
   logic [7:0] acc_q;
   logic zero_q;
   logic sleep_q;
   logic expiry_q;
   logic [DOG_WIDTH-1:0] dog_q;
   logic [PRESCALE_WIDTH-1:0] pre_q;
   logic [13:0] word_q;
   exec_state_t state_q;
   logic ph_write_q;
   logic ph_read_q;
   logic [7:0] ph_addr_q;
   logic [31:0] rdata_q;
   logic busy_q;

   // ------------------------------------------------------------
   // Bus address phase
   // ------------------------------------------------------------
   logic take;
   logic [6:0] faddr;
   logic [7:0] freg;
   logic [7:0] result;
   logic is_clr;
   logic is_inv;
   logic is_dec;
   logic is_kick;
   logic to_file;
   logic exec;

   // Bus acceptance, operand select and destination decode
   assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
   assign faddr = word_q[FADDR_MSB:0];
   assign freg = file_q[faddr];
   assign exec = (state_q == ST_EXEC);
   assign to_file = word_q[DEST_BIT];

   // Decode and result logic; pure combinational, holds no state
   exec_alu exec_alu_i (
      .word_in(word_q),
      .freg_in(freg),
      .result_out(result),
      .is_acc_clear_out(is_clr),
      .is_invert_out(is_inv),
      .is_minus_out(is_dec),
      .is_kick_out(is_kick)
   );

   // Latch address phase; zero-wait slave
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ph_write_q <= 1'b0;
         ph_read_q <= 1'b0;
         ph_addr_q <= 8'h00;
      end else begin
         ph_write_q <= take && HWRITE_IN;
         ph_read_q <= take && !HWRITE_IN;
         if (take) begin
            ph_addr_q <= HADDR_IN[7:0];
         end
      end
   end

   // Instruction register write kicks one execution cycle
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         word_q <= 14'h0000;
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (ph_write_q && ph_addr_q == INSTR_OFFSET) begin
                  word_q <= HWDATA_IN[13:0];
                  state_q <= ST_EXEC;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Accumulator: execution result has priority over bus write
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         acc_q <= ACC_RESET;
      end else if (exec && is_clr) begin
         acc_q <= 8'h00;
      end else if (exec && (is_inv || is_dec) && !to_file) begin
         acc_q <= result;
      end else if (ph_write_q && ph_addr_q == ACC_OFFSET) begin
         acc_q <= HWDATA_IN[7:0];
      end
   end

   // File registers; no reset, contents are software-defined
   always_ff @(posedge MCLK_IN) begin
      if (exec && (is_inv || is_dec) && to_file) begin
         file_q[faddr] <= result;
      end else if (ph_write_q && ph_addr_q[7]) begin
         file_q[ph_addr_q[6:0]] <= HWDATA_IN[7:0];
      end
   end

   // Status flags
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         zero_q <= STATUS_RESET[ZERO_POS];
         sleep_q <= STATUS_RESET[SLEEP_POS];
         expiry_q <= STATUS_RESET[EXPIRY_POS];
      end else if (exec && is_clr) begin
         zero_q <= 1'b1;
      end else if (exec && (is_inv || is_dec)) begin
         zero_q <= (result == 8'h00);
      end else if (exec && is_kick) begin
         // Zero flag left untouched
         sleep_q <= 1'b1;
         expiry_q <= 1'b1;
      end else if (ph_write_q && ph_addr_q == STATUS_OFFSET) begin
         zero_q <= HWDATA_IN[ZERO_POS];
         sleep_q <= HWDATA_IN[SLEEP_POS];
         expiry_q <= HWDATA_IN[EXPIRY_POS];
      end
   end

   // Watchdog counter and prescaler; free-running stand-in timebase
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         dog_q <= '0;
         pre_q <= '0;
      end else if (exec && is_kick) begin
         dog_q <= '0;
         pre_q <= '0;
      end else begin
         // Counter wraps silently; no expiry action in this block
         pre_q <= pre_q + 1'b1;
         if (&pre_q) begin
            dog_q <= dog_q + 1'b1;
         end
      end
   end

   // Read mux, registered for the data phase
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rdata_q <= 32'h0000_0000;
      end else if (take && !HWRITE_IN) begin
         if (HADDR_IN[7]) begin
            rdata_q <= {24'h000000, file_q[HADDR_IN[6:0]]};
         end else if (HADDR_IN[7:0] == INSTR_OFFSET) begin
            rdata_q <= {18'h00000, word_q};
         end else if (HADDR_IN[7:0] == ACC_OFFSET) begin
            rdata_q <= {24'h000000, acc_q};
         end else if (HADDR_IN[7:0] == STATUS_OFFSET) begin
            rdata_q <= {29'h0, expiry_q, sleep_q, zero_q};
         end else if (HADDR_IN[7:0] == DOG_OFFSET) begin
            rdata_q <= {24'h000000, 8'(dog_q)};
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   // Busy and counter outputs
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_q == ST_IDLE) && ph_write_q
            && (ph_addr_q == INSTR_OFFSET);
      end
   end

   assign HRDATA_OUT = rdata_q;
   assign HREADYOUT_OUT = 1'b1; // Every access completes with no wait
   assign HRESP_OUT = 1'b0;
   assign DOG_COUNT_OUT = 8'(dog_q);
   assign BUSY_OUT = busy_q;

endmodule : exec_top
`default_nettype wire

// ==== verification/exec_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the executor
// ----------------------------------------
module exec_top_checker
   import exec_pkg::*;
#(
   parameter int PRESCALE_WIDTH = 8
) (
   // Clock, reset and bus
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   // Outputs watched
   input wire logic [31:0] HRDATA_OUT,
   input wire logic [7:0] DOG_COUNT_OUT,
   input wire logic BUSY_OUT
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   logic rd_q, wr_q;
   logic [7:0] a_q, f_q;
   logic [13:0] op_q;
   wire logic take = HSEL_IN & HREADY_IN & HTRANS_IN[1];
   wire logic inv = op_q[13:8] == INVERT_OPC;
   wire logic dec = op_q[13:8] == MINUS_ONE_OPC;
   wire logic [7:0] res = inv ? ~f_q : f_q - 8'h01;
   wire logic iw = wr_q && a_q == INSTR_OFFSET;
   wire logic rs = rd_q && a_q == STATUS_OFFSET;
   wire logic ra = rd_q && a_q == ACC_OFFSET;
   // Data phase kind of the last accepted address phase
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         a_q <= 8'h00;
      end else begin
         rd_q <= take & ~HWRITE_IN;
         wr_q <= take & HWRITE_IN;
         a_q <= HADDR_IN[7:0];
      end
   end
   // Last word run and last operand read; other writes spoil it
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         op_q <= 14'h0000;
         f_q <= 8'h00;
      end else if (wr_q) begin
         op_q <= iw ? HWDATA_IN[13:0] : 14'h0000;
      end else if (rd_q && a_q[7]) begin
         f_q <= HRDATA_OUT[7:0];
      end
   end
   busy_single_a: assert property ($rose(BUSY_OUT) |=> !BUSY_OUT)
      else $error("busy held too long");
   busy_follow_a: assert property (iw && HWDATA_IN[13:0] ==
      ACC_CLEAR_WORD |-> ##[0:2] BUSY_OUT) else $error("no busy");
   presc_zero_a: assert property (iw && PRESCALE_WIDTH > 2 &&
      HWDATA_IN[13:0] == KICK_DOG_WORD |-> ##2 (DOG_COUNT_OUT == 8'h00)[*6])
      else $error("watchdog not cleared");
   acc_clear_a: assert property (ra && op_q == ACC_CLEAR_WORD
      |-> HRDATA_OUT == 32'h0) else $error("acc not cleared");
   zero_set_a: assert property (rs && op_q == ACC_CLEAR_WORD
      |-> HRDATA_OUT[0]) else $error("zero flag not set");
   dog_flags_a: assert property (rs && op_q == KICK_DOG_WORD
      |-> HRDATA_OUT[2:1] == 2'b11) else $error("flags not set");
   acc_result_a: assert property (
      ra && (inv || dec) && !op_q[7]
      |-> HRDATA_OUT[7:0] == res) else $error("acc result wrong");
   zero_track_a: assert property (rs && (inv || dec)
      |-> HRDATA_OUT[0] == (res == 8'h00)) else $error("zero wrong");
   cover property (rs && op_q == KICK_DOG_WORD);
   cover property (ra && inv);
   cover property (ra && dec);
endmodule : exec_top_checker

bind exec_top exec_top_checker #(.PRESCALE_WIDTH(PRESCALE_WIDTH))
   exec_top_checker_i (.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN),
   .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN),
   .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN),
   .HRDATA_OUT(HRDATA_OUT), .DOG_COUNT_OUT(DOG_COUNT_OUT),
   .BUSY_OUT(BUSY_OUT));
`default_nettype wire

// ==== verification/exec_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench for the executor
// ----------------------------------------
module exec_top_tb
   import exec_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hready, hresp, busy;
   logic [7:0] dog;
   int err_total = 0, num_checks = 0;
   // Short counts keep the watchdog busy within a brief run
   localparam int PRE_W = 3;
   exec_top #(.DOG_WIDTH(4), .PRESCALE_WIDTH(PRE_W)) exec_top_i (
      .MCLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
      .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .DOG_COUNT_OUT(dog), .BUSY_OUT(busy));
   initial forever #25 clk = ~clk;
   task automatic check(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask : check
   // Single transfer; holds each phase until ready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      check(nm, r, e);
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask : rd
   // Busy marks the one execution cycle; results stand after it
   task automatic run(input logic [13:0] w);
      wr(INSTR_OFFSET, {18'h0, w});
      @(negedge clk);
      check("busy", {31'h0, busy}, 32'h1);
      @(negedge clk);
      check("busy", {31'h0, busy}, 32'h0);
   endtask : run
   // Reset values and an unmapped hole, read before any write
   task automatic s_reset;
      rd(STATUS_OFFSET, {29'h0, STATUS_RESET}, "status reset");
      rd(ACC_OFFSET, {24'h0, ACC_RESET}, "acc reset");
      rd(8'h10, 32'h0, "unmapped");
   endtask : s_reset
   task automatic s_clear;
      wr(ACC_OFFSET, 32'h5a);
      wr(STATUS_OFFSET, 32'h0);
      run(ACC_CLEAR_WORD);
      rd(STATUS_OFFSET, 32'h1, "status");
      rd(ACC_OFFSET, 32'h0, "acc");
      rd(INSTR_OFFSET, {18'h0, ACC_CLEAR_WORD}, "word");
   endtask : s_clear
   task automatic s_op(input logic [5:0] o, input logic d,
                       input logic [7:0] f, q);
      wr(8'h84, {24'h0, f});
      rd(8'h84, {24'h0, f}, "operand");
      wr(ACC_OFFSET, 32'h5a);
      wr(STATUS_OFFSET, 32'h0);
      run({o, d, 7'h04});
      rd(STATUS_OFFSET, {31'h0, q == 8'h00}, "zero");
      rd(ACC_OFFSET, {24'h0, d ? 8'h5a : q}, "acc");
      rd(8'h84, {24'h0, d ? q : f}, "file");
   endtask : s_op
   // Kick mid-count; the next count step must take a full prescale
   task automatic s_kick;
      int n;
      n = 0;
      wr(STATUS_OFFSET, 32'h1);
      while (dog != 8'h02) @(negedge clk);
      run(KICK_DOG_WORD);
      check("dog", {24'h0, dog}, 32'h0);
      while (dog == 8'h00 && n < 64) begin
         @(negedge clk);
         n++;
      end
      check("prescaler", n, 1 << PRE_W);
      rd(DOG_OFFSET, 32'h1, "dog reg");
      rd(STATUS_OFFSET, 32'h7, "status");
   endtask : s_kick
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      s_reset();
      s_clear();
      s_op(INVERT_OPC, 1'b0, 8'h13, 8'hec);
      s_op(INVERT_OPC, 1'b1, 8'hff, 8'h00);
      s_op(MINUS_ONE_OPC, 1'b1, 8'h01, 8'h00);
      s_op(MINUS_ONE_OPC, 1'b0, 8'h00, 8'hff);
      s_kick();
      test_done();
   end
   // Hang guard, far beyond the fewer than two hundred cycles the tests need
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule : exec_top_tb
`default_nettype wire
